/* File: hdl/flash_option_protection.sv */
// How it works
// - program array 64 pages, info pages one each
// - erase by page, write aligned half-words
// - program array at zero only in normal boot
// - factory page fixed; aliased at zero in monitor
// - user page mapped; instruction fetches refused
// - option high byte forced to complement
// - complement mismatch at reset holds processor
// - sixteen four-page regions from bytes 4, 5
// - active-low protect bits, effective after reset
// - protected region blocks program and erase
// - read protection off only for key 0xa5
// - read protection state changes only at reset
// - debugger latches intrusion; under read protection both disconnect flash
// - intrusion cleared by pin reset, debugger gone
// - option erase under protection mass-erases array
// - read protection locks lowest four pages
// - bytes 1,2,3,6,7 drive only the check and the option readback
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none

module flash_option_protection
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_por_rst,
    input wire logic i_clk_en,
    input wire logic i_boot_monitor,
    input wire logic i_pin_reset_cause,
    input wire logic i_debug_connected,
    output logic o_ld_rd,
    output logic [2:0] o_ld_idx,
    input wire logic [15:0] i_ld_data,
    input wire logic i_bus_req,
    input wire flash_prot_pkg::bus_req_s i_bus,
    output flash_prot_pkg::bus_rsp_s o_bus_rsp,
    input wire logic i_cmd_valid,
    input wire flash_prot_pkg::cmd_s i_cmd,
    output flash_prot_pkg::flash_op_s o_flash_op,
    output logic o_cmd_err,
    output logic o_mass_erase,
    output logic o_cpu_hold,
    output logic o_option_error,
    output logic o_flash_disconnect,
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        flash_prot_pkg::phase_e phase;
        logic [1:0] settle;
        logic [2:0] ld_idx;
        logic ld_rd;
        logic ld_cap;
        logic [7:0][15:0] opt;
        logic monitor;
        logic rdprot;
        logic [15:0] wprot;
        logic ob0_erased;
        logic cmd_en;
        logic intr_clr;
        logic cpu_hold;
        logic opt_err;
        logic disc;
        flash_prot_pkg::bus_rsp_s bus_rsp;
        flash_prot_pkg::flash_op_s op;
        logic cmd_err;
        logic mass_erase;
        logic [31:0] rdata;
    } core_s;

    core_s st_reg;
    core_s st_next;
    logic intrusion;
    logic debug_present;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // block selection by address and boot mode; offset is within the block
    function automatic flash_prot_pkg::bus_rsp_s decode(input logic [31:0] addr,
                                                        input logic monitor);
        flash_prot_pkg::bus_rsp_s r;
        r = '0;
        if (addr[31:17] == flash_prot_pkg::PROG_BASE[31:17])
        begin
            r.target = flash_prot_pkg::TGT_PROG;
            r.offset = addr[16:0];
        end
        else if (addr[31:11] == flash_prot_pkg::FACT_BASE[31:11])
        begin
            r.target = flash_prot_pkg::TGT_FACT;
            r.offset = {6'h00, addr[10:0]};
        end
        else if (addr[31:11] == flash_prot_pkg::USER_BASE[31:11])
        begin
            r.target = flash_prot_pkg::TGT_USER;
            r.offset = {6'h00, addr[10:0]};
        end
        else if (monitor)
        begin
            if (addr[31:11] == flash_prot_pkg::ALIAS_BASE[31:11])
            begin
                r.target = flash_prot_pkg::TGT_FACT;
                r.offset = {6'h00, addr[10:0]};
            end
        end
        else if (addr[31:17] == flash_prot_pkg::ALIAS_BASE[31:17])
        begin
            r.target = flash_prot_pkg::TGT_PROG;
            r.offset = addr[16:0];
        end
        return r;
    endfunction

    function automatic logic options_intact(input logic [7:0][15:0] opt);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < flash_prot_pkg::OPT_COUNT; i++)
        begin
            if (opt[i][15:8] != ~opt[i][7:0])
            begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    // ----------------------------------------------------------------
    // debugger intrusion latch
    // ----------------------------------------------------------------
    intrusion_latch u_intrusion
    (
        .i_ref_clk(i_ref_clk),
        .i_por_rst(i_por_rst),
        .i_clk_en(i_clk_en),
        .i_debug_connected(i_debug_connected),
        .i_clear(st_reg.intr_clr),
        .o_intrusion(intrusion),
        .o_debug_present(debug_present)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        flash_prot_pkg::bus_rsp_s b;
        flash_prot_pkg::bus_rsp_s c;
        logic refuse;
        logic running;
        logic [3:0] region;
        logic [15:0] data;
        logic erased;
        st_next = st_reg;
        b = '0;
        c = '0;
        refuse = 1'b0;
        region = 4'h0;
        data = 16'h0000;
        erased = st_reg.ob0_erased;
        running = (st_reg.phase == flash_prot_pkg::PH_RUN);
        st_next.intr_clr = 1'b0;
        st_next.ld_rd = 1'b0;
        st_next.ld_cap = st_reg.ld_rd;
        st_next.bus_rsp = '0;
        st_next.op = '0;
        st_next.cmd_err = 1'b0;
        st_next.mass_erase = 1'b0;
        st_next.disc = st_reg.rdprot & intrusion;

        // ------------------------------------------------------------
        // option load after reset release
        // ------------------------------------------------------------
        unique case (st_reg.phase)
            flash_prot_pkg::PH_SETTLE:
            begin
                // let the debugger synchroniser fill before judging it
                st_next.settle = st_reg.settle + 2'd1;
                if (st_reg.settle == 2'd3)
                begin
                    st_next.monitor = i_boot_monitor;
                    st_next.intr_clr = i_pin_reset_cause & ~debug_present;
                    st_next.phase = flash_prot_pkg::PH_LOAD;
                    st_next.ld_rd = 1'b1;
                end
            end
            flash_prot_pkg::PH_LOAD:
            begin
                if (st_reg.ld_cap)
                begin
                    st_next.opt[st_reg.ld_idx] = i_ld_data;
                    if (st_reg.ld_idx == 3'd7)
                    begin
                        st_next.phase = flash_prot_pkg::PH_CHECK;
                    end
                    else
                    begin
                        st_next.ld_idx = st_reg.ld_idx + 3'd1;
                        st_next.ld_rd = 1'b1;
                    end
                end
            end
            flash_prot_pkg::PH_CHECK:
            begin
                // bytes 1,2,3,6,7 take part in this check and the option readback only
                if (options_intact(st_reg.opt))
                begin
                    st_next.phase = flash_prot_pkg::PH_RUN;
                    st_next.cpu_hold = 1'b0;
                end
                else
                begin
                    st_next.phase = flash_prot_pkg::PH_FAULT;
                    st_next.opt_err = 1'b1;
                end
                st_next.rdprot = st_reg.opt[flash_prot_pkg::OPT_RDPROT_IDX][7:0]
                                 != flash_prot_pkg::RDPROT_OFF_KEY;
                st_next.wprot = ~{st_reg.opt[flash_prot_pkg::OPT_WP_HI_IDX][7:0],
                                  st_reg.opt[flash_prot_pkg::OPT_WP_LO_IDX][7:0]};
                if (st_next.rdprot)
                begin
                    st_next.wprot[0] = 1'b1;
                end
                st_next.ob0_erased = st_reg.opt[flash_prot_pkg::OPT_RDPROT_IDX]
                                     == flash_prot_pkg::OPT_ERASED;
            end
            flash_prot_pkg::PH_RUN:
            begin
            end
            flash_prot_pkg::PH_FAULT:
            begin
            end
        endcase

        // ------------------------------------------------------------
        // bus access check
        // ------------------------------------------------------------
        if (i_bus_req)
        begin
            b = decode(i_bus.addr, st_reg.monitor);
            b.valid = 1'b1;
            b.err = ~running | st_reg.disc | (b.target == flash_prot_pkg::TGT_NONE);
            if (i_bus.fetch && b.target == flash_prot_pkg::TGT_USER)
            begin
                b.err = 1'b1;
            end
            st_next.bus_rsp = b;
        end

        // ------------------------------------------------------------
        // program and erase commands
        // ------------------------------------------------------------
        if (i_cmd_valid)
        begin
            c = decode(i_cmd.addr, st_reg.monitor);
            region = c.offset[16:13];
            data = i_cmd.data;
            refuse = ~running | ~st_reg.cmd_en | st_reg.disc;
            // factory page is never writable from here
            if (c.target != flash_prot_pkg::TGT_PROG && c.target != flash_prot_pkg::TGT_USER)
            begin
                refuse = 1'b1;
            end
            unique case (i_cmd.kind)
                flash_prot_pkg::CMD_PROGRAM:
                begin
                    refuse = refuse | i_cmd.addr[0];
                    if (c.target == flash_prot_pkg::TGT_PROG && st_reg.wprot[region])
                    begin
                        refuse = 1'b1;
                    end
                    if (c.target == flash_prot_pkg::TGT_USER && c.offset[10:4] == 7'h00)
                    begin
                        data = {~i_cmd.data[7:0], i_cmd.data[7:0]};
                        if (c.offset[3:1] == 3'd0)
                        begin
                            refuse = refuse | ~st_reg.ob0_erased;
                            erased = 1'b0;
                        end
                    end
                end
                flash_prot_pkg::CMD_PAGE_ERASE:
                begin
                    if (c.target == flash_prot_pkg::TGT_PROG && st_reg.wprot[region])
                    begin
                        refuse = 1'b1;
                    end
                    if (c.target == flash_prot_pkg::TGT_USER)
                    begin
                        erased = 1'b1;
                    end
                    // page granularity: offset within page is dropped
                    c.offset[10:0] = 11'h000;
                end
                flash_prot_pkg::CMD_MASS_ERASE:
                begin
                    refuse = refuse | (|st_reg.wprot) | (c.target != flash_prot_pkg::TGT_PROG);
                    c.offset = '0;
                end
                default:
                begin
                    refuse = 1'b1;
                end
            endcase
            st_next.cmd_err = refuse;
            if (!refuse)
            begin
                st_next.op.valid = 1'b1;
                st_next.op.kind = i_cmd.kind;
                st_next.op.target = c.target;
                st_next.op.offset = c.offset;
                st_next.op.data = data;
                st_next.ob0_erased = erased;
                if (i_cmd.kind == flash_prot_pkg::CMD_PAGE_ERASE
                    && c.target == flash_prot_pkg::TGT_USER)
                begin
                    st_next.mass_erase = st_reg.rdprot;
                end
            end
        end

        // ------------------------------------------------------------
        // register port
        // ------------------------------------------------------------
        if (i_reg_wr && i_reg_addr == flash_prot_pkg::REG_CTRL)
        begin
            st_next.cmd_en = i_reg_wdata[flash_prot_pkg::CTRL_CMD_EN_BIT];
        end
        st_next.rdata = 32'h0000_0000;
        if (i_reg_rd)
        begin
            unique case (i_reg_addr)
                flash_prot_pkg::REG_STATUS:
                    st_next.rdata = {24'h000000, st_reg.ob0_erased, debug_present,
                                     st_reg.monitor, st_reg.disc, intrusion,
                                     st_reg.rdprot, st_reg.opt_err, running};
                flash_prot_pkg::REG_OPT_LO:
                    st_next.rdata = {st_reg.opt[3][7:0], st_reg.opt[2][7:0],
                                     st_reg.opt[1][7:0], st_reg.opt[0][7:0]};
                flash_prot_pkg::REG_OPT_HI:
                    st_next.rdata = {st_reg.opt[7][7:0], st_reg.opt[6][7:0],
                                     st_reg.opt[5][7:0], st_reg.opt[4][7:0]};
                flash_prot_pkg::REG_WPROT:
                    st_next.rdata = {16'h0000, st_reg.wprot};
                flash_prot_pkg::REG_CTRL:
                    st_next.rdata = {31'h00000000, st_reg.cmd_en};
                default:
                    st_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // fail safe out of reset: processor held, everything protected
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_reg <= '0;
            st_reg.phase <= flash_prot_pkg::PH_SETTLE;
            st_reg.cpu_hold <= 1'b1;
            st_reg.rdprot <= 1'b1;
            st_reg.wprot <= 16'hffff;
            st_reg.cmd_en <= flash_prot_pkg::CTRL_RESET;
        end
        else if (i_clk_en)
        begin
            st_reg <= st_next;
        end
    end

    assign o_ld_rd = st_reg.ld_rd;
    assign o_ld_idx = st_reg.ld_idx;
    assign o_bus_rsp = st_reg.bus_rsp;
    assign o_flash_op = st_reg.op;
    assign o_cmd_err = st_reg.cmd_err;
    assign o_mass_erase = st_reg.mass_erase;
    assign o_cpu_hold = st_reg.cpu_hold;
    assign o_option_error = st_reg.opt_err;
    assign o_flash_disconnect = st_reg.disc;
    assign o_reg_rdata = st_reg.rdata;

endmodule

`default_nettype wire

/* File: hdl/flash_prot_pkg.sv */
package flash_prot_pkg;

    // ----------------------------------------------------------------
    // flash organisation
    // ----------------------------------------------------------------
    localparam int unsigned PAGE_BYTES = 2048;
    localparam int unsigned PAGE_COUNT = 64;
    localparam int unsigned REGION_PAGES = 4;
    localparam int unsigned REGION_COUNT = 16;
    localparam int unsigned OPT_COUNT = 8;

    // address map: bits above the block size select the block
    localparam logic [31:0] PROG_BASE = 32'h0800_0000;
    localparam logic [31:0] FACT_BASE = 32'h0804_0000;
    localparam logic [31:0] USER_BASE = 32'h0804_0800;
    localparam logic [31:0] ALIAS_BASE = 32'h0000_0000;

    // ----------------------------------------------------------------
    // option bytes
    // ----------------------------------------------------------------
    localparam logic [7:0] RDPROT_OFF_KEY = 8'ha5;
    localparam logic [15:0] OPT_ERASED = 16'hffff;
    localparam int unsigned OPT_RDPROT_IDX = 0;
    localparam int unsigned OPT_WP_LO_IDX = 4;
    localparam int unsigned OPT_WP_HI_IDX = 5;

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_OPT_LO = 8'h04;
    localparam logic [7:0] REG_OPT_HI = 8'h08;
    localparam logic [7:0] REG_WPROT = 8'h0c;
    localparam logic [7:0] REG_CTRL = 8'h10;
    localparam int unsigned CTRL_CMD_EN_BIT = 0;
    localparam logic CTRL_RESET = 1'b0;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {PH_SETTLE, PH_LOAD, PH_CHECK, PH_RUN, PH_FAULT} phase_e;
    typedef enum logic [1:0] {TGT_NONE, TGT_PROG, TGT_FACT, TGT_USER} target_e;
    typedef enum logic [1:0] {CMD_PROGRAM, CMD_PAGE_ERASE, CMD_MASS_ERASE} cmd_kind_e;

    typedef struct packed {
        logic [31:0] addr;
        logic fetch;
    } bus_req_s;

    typedef struct packed {
        logic valid;
        target_e target;
        logic [16:0] offset;
        logic err;
    } bus_rsp_s;

    typedef struct packed {
        cmd_kind_e kind;
        logic [31:0] addr;
        logic [15:0] data;
    } cmd_s;

    typedef struct packed {
        logic valid;
        cmd_kind_e kind;
        target_e target;
        logic [16:0] offset;
        logic [15:0] data;
    } flash_op_s;

    typedef struct packed {
        logic [2:0] sync;
        logic present;
        logic flag;
    } intr_s;

endpackage

/* File: hdl/intrusion_latch.sv */
`timescale 1ns/1ns
`default_nettype none

module intrusion_latch
(
    input wire logic i_ref_clk,
    input wire logic i_por_rst,
    input wire logic i_clk_en,
    input wire logic i_debug_connected,
    input wire logic i_clear,
    output logic o_intrusion,
    output logic o_debug_present
);

    flash_prot_pkg::intr_s st_reg;
    flash_prot_pkg::intr_s st_next;

    always_comb
    begin
        st_next = st_reg;
        st_next.sync = {st_reg.sync[1:0], i_debug_connected};
        // a change counts only once the last two stages agree
        if (st_reg.sync[2] == st_reg.sync[1])
        begin
            st_next.present = st_reg.sync[2];
        end
        // a connected debugger wins over a clear in the same cycle
        if (st_next.present)
        begin
            st_next.flag = 1'b1;
        end
        else if (i_clear)
        begin
            st_next.flag = 1'b0;
        end
    end

    // only power-on resets this register; chip resets clear the flag only through i_clear
    always_ff @(posedge i_ref_clk or posedge i_por_rst)
    begin
        if (i_por_rst)
        begin
            st_reg <= '0;
        end
        else if (i_clk_en)
        begin
            st_reg <= st_next;
        end
    end

    assign o_intrusion = st_reg.flag;
    assign o_debug_present = st_reg.present;

endmodule

`default_nettype wire

/* File: verification/flash_option_protection_props.sv */
`timescale 1ns/1ns
`default_nettype none
module flash_prot_checker
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_bus_req,
    input wire flash_prot_pkg::bus_req_s i_bus,
    input wire flash_prot_pkg::bus_rsp_s o_bus_rsp,
    input wire logic i_cmd_valid,
    input wire flash_prot_pkg::cmd_s i_cmd,
    input wire flash_prot_pkg::flash_op_s o_flash_op,
    input wire logic o_cmd_err,
    input wire logic o_mass_erase,
    input wire logic o_cpu_hold,
    input wire logic o_option_error,
    input wire logic o_flash_disconnect,
    input wire logic i_reg_rd,
    input wire logic [31:0] o_reg_rdata
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    sequence ask_s; i_bus_req; endsequence
    sequence answer_s; o_bus_rsp.valid; endsequence
    sequence order_s; i_cmd_valid; endsequence
    sequence reply_s; o_flash_op.valid ^ o_cmd_err; endsequence
    rsp_time_a: assert property (ask_s |=> answer_s) else $error("bus not answered");
    rsp_quiet_a: assert property (!i_bus_req |=> !o_bus_rsp.valid) else $error("stray bus answer");
    cmd_reply_a: assert property (order_s |=> reply_s) else $error("cmd not answered");
    cmd_quiet_a: assert property (!i_cmd_valid |=> !(o_flash_op.valid || o_cmd_err))
        else $error("stray cmd answer");
    fetch_user_a: assert property (i_bus_req && i_bus.fetch
        && i_bus.addr[31:11] == flash_prot_pkg::USER_BASE[31:11] |=> o_bus_rsp.err)
        else $error("user page fetch allowed");
    odd_prog_a: assert property (i_cmd_valid && i_cmd.addr[0]
        && i_cmd.kind == flash_prot_pkg::CMD_PROGRAM |=> o_cmd_err) else $error("odd write taken");
    disc_err_a: assert property (o_flash_disconnect && i_bus_req |=> o_bus_rsp.err)
        else $error("access while disconnected");
    disc_hold_a: assert property (!o_cpu_hold && o_flash_disconnect |=> o_flash_disconnect)
        else $error("disconnect dropped");
    err_hold_a: assert property (o_option_error |-> o_cpu_hold) else $error("cpu runs");
    mass_pair_a: assert property (o_mass_erase |-> o_flash_op.valid
        && o_flash_op.target == flash_prot_pkg::TGT_USER) else $error("lone mass erase");
    rdata_zero_a: assert property (!i_reg_rd |=> o_reg_rdata == 32'h0) else $error("stray rdata");
endmodule
bind flash_option_protection flash_prot_checker u_chk (.*);
`default_nettype wire

/* File: verification/opt_store_model.sv */
`timescale 1ns/1ns
`default_nettype none
module opt_store_model
(
    input wire logic i_ref_clk,
    input wire logic i_rd,
    input wire logic [2:0] i_idx,
    input wire logic [127:0] i_words,
    output logic [15:0] o_data
);
    // toggles when idle: a late capture fails
    always @(posedge i_ref_clk)
    begin
        if (i_rd)
            o_data <= i_words[i_idx*16 +: 16];
        else
            o_data <= ~o_data;
    end
endmodule
`default_nettype wire

/* File: verification/test_flash_option_protection.sv */
`timescale 1ns/1ns
`default_nettype none
module test_flash_option_protection;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b0;
    logic i_por_rst = 1'b0;
    logic boot_mon = 1'b0;
    logic pin_cause = 1'b1;
    logic dbg = 1'b0;
    logic ld_rd;
    logic [2:0] ld_idx;
    logic [15:0] ld_data;
    logic bus_req = 1'b0;
    flash_prot_pkg::bus_req_s bus = '0;
    flash_prot_pkg::bus_rsp_s rsp;
    logic cmd_valid = 1'b0;
    flash_prot_pkg::cmd_s cmd = '0;
    flash_prot_pkg::flash_op_s op;
    logic cmd_err, mass, hold, opt_err, disc;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [127:0] words = '1;
    int n_mismatch = 0;
    int samples_checked = 0;
    localparam logic [1:0] TN = flash_prot_pkg::TGT_NONE, TP = flash_prot_pkg::TGT_PROG,
        TF = flash_prot_pkg::TGT_FACT, TU = flash_prot_pkg::TGT_USER;
    localparam flash_prot_pkg::cmd_kind_e PG = flash_prot_pkg::CMD_PROGRAM,
        PE = flash_prot_pkg::CMD_PAGE_ERASE;
    always #4 i_ref_clk = ~i_ref_clk;
    flash_option_protection DUT (.i_ref_clk, .i_rst, .i_por_rst,
        .i_clk_en(1'b1), .i_boot_monitor(boot_mon), .i_pin_reset_cause(pin_cause),
        .i_debug_connected(dbg), .o_ld_rd(ld_rd), .o_ld_idx(ld_idx), .i_ld_data(ld_data),
        .i_bus_req(bus_req), .i_bus(bus), .o_bus_rsp(rsp), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
        .o_flash_op(op), .o_cmd_err(cmd_err), .o_mass_erase(mass), .o_cpu_hold(hold),
        .o_option_error(opt_err), .o_flash_disconnect(disc), .i_reg_addr(reg_addr),
        .i_reg_wdata(wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(rdata));
    opt_store_model u_store (.i_ref_clk(i_ref_clk), .i_rd(ld_rd), .i_idx(ld_idx),
        .i_words(words), .o_data(ld_data));
    // ----------
    // bus cycles
    // ----------
    function automatic logic [127:0] opts(input logic [7:0] b0, b4, b5);
        logic [127:0] w;
        w = {8{16'h00ff}};
        w[15:0] = {~b0, b0};
        w[79:64] = {~b4, b4};
        w[95:80] = {~b5, b5};
        return w;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        wdata <= d;
        @(posedge i_ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        @(posedge i_ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge i_ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(rdata & m, exp);
    endtask
    task automatic bus_chk(input logic [31:0] a, input logic f, input logic [1:0] t,
        input logic e);
        @(posedge i_ref_clk);
        bus_req <= 1'b1;
        bus <= '{a, f};
        @(posedge i_ref_clk);
        bus_req <= 1'b0;
        #1;
        chk(32'({rsp.valid, rsp.err}), 32'({1'b1, e}));
        if (!e) chk(32'(rsp.target), 32'(t));
    endtask
    task automatic cmd_chk(input flash_prot_pkg::cmd_kind_e k, input logic [31:0] a,
        input logic [15:0] d, input logic ok, me);
        @(posedge i_ref_clk);
        cmd_valid <= 1'b1;
        cmd <= '{k, a, d};
        @(posedge i_ref_clk);
        cmd_valid <= 1'b0;
        #1;
        chk(32'({op.valid, cmd_err, mass}), 32'({ok, ~ok, me}));
    endtask
    task automatic boot(input logic [127:0] w, input logic m, p, por);
        @(posedge i_ref_clk);
        i_rst <= 1'b1;
        i_por_rst <= por;
        words <= w;
        boot_mon <= m;
        pin_cause <= p;
        repeat (10) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        i_por_rst <= 1'b0;
        for (int k = 0; k < 60 && hold !== 1'b0; k++) @(negedge i_ref_clk);
        wr(flash_prot_pkg::REG_CTRL, 32'h1);
    endtask
    // ----------
    // scenarios
    // ----------
    task automatic t_normal;
        boot(opts(8'ha5, 8'hff, 8'hff), 1'b0, 1'b1, 1'b1);
        rd(flash_prot_pkg::REG_STATUS, 32'h7, 32'h1);
        rd(flash_prot_pkg::REG_WPROT, 32'hffff, 32'h0000);
        rd(8'h20, '1, 32'h0);
        bus_chk(32'h0800_0010, 1'b0, TP, 1'b0);
        bus_chk(32'h0000_0010, 1'b0, TP, 1'b0);
        bus_chk(32'h0804_0000, 1'b0, TF, 1'b0);
        bus_chk(32'h0804_0800, 1'b1, TU, 1'b1);
        bus_chk(32'h1000_0000, 1'b0, TN, 1'b1);
        cmd_chk(PG, 32'h0800_2000, 16'h1234, 1'b1, 1'b0);
        chk(32'(op.offset), 32'h2000);
        cmd_chk(PG, 32'h0800_2001, 16'h1234, 1'b0, 1'b0);
        cmd_chk(PE, 32'h0802_0000, 16'h0, 1'b0, 1'b0);
        cmd_chk(PG, 32'h0804_0804, 16'h0012, 1'b1, 1'b0);
        chk(32'(op.data), 32'hed12);
    endtask
    task automatic t_wprot;
        boot(opts(8'ha5, 8'hff, 8'hfe), 1'b0, 1'b1, 1'b0);
        words <= opts(8'ha5, 8'hff, 8'hff);
        rd(flash_prot_pkg::REG_WPROT, 32'hffff, 32'h0100);
        cmd_chk(PG, 32'h0801_0000, 16'h5555, 1'b0, 1'b0);
        cmd_chk(PE, 32'h0801_1800, 16'h0, 1'b0, 1'b0);
        cmd_chk(PG, 32'h0801_2000, 16'h5555, 1'b1, 1'b0);
    endtask
    task automatic t_rdprot;
        boot(opts(8'hff, 8'hff, 8'hff), 1'b0, 1'b1, 1'b0);
        words <= opts(8'ha5, 8'hff, 8'hff);
        rd(flash_prot_pkg::REG_STATUS, 32'h4, 32'h4);
        rd(flash_prot_pkg::REG_WPROT, 32'hffff, 32'h0001);
        cmd_chk(PG, 32'h0800_1ffe, 16'h0, 1'b0, 1'b0);
        cmd_chk(PE, 32'h0804_0800, 16'h0, 1'b1, 1'b1);
        dbg <= 1'b1;
        repeat (8) @(posedge i_ref_clk);
        words <= opts(8'hff, 8'hff, 8'hff);
        bus_chk(32'h0800_0000, 1'b0, TP, 1'b1);
        chk(32'(disc), 32'h1);
        dbg <= 1'b0;
        boot(opts(8'hff, 8'hff, 8'hff), 1'b0, 1'b0, 1'b0);
        chk(32'(disc), 32'h1);
        boot(opts(8'hff, 8'hff, 8'hff), 1'b0, 1'b1, 1'b0);
        chk(32'(disc), 32'h0);
    endtask
    task automatic t_bad_and_monitor;
        logic [127:0] w;
        w = opts(8'ha5, 8'hff, 8'hff);
        w[56] = ~w[56];
        boot(w, 1'b0, 1'b1, 1'b0);
        chk(32'({opt_err, hold}), 32'h3);
        bus_chk(32'h0800_0000, 1'b0, TP, 1'b1);
        boot(opts(8'ha5, 8'hff, 8'hff), 1'b1, 1'b1, 1'b0);
        bus_chk(32'h0000_0000, 1'b0, TF, 1'b0);
        bus_chk(32'h0000_1000, 1'b0, TN, 1'b1);
        bus_chk(32'h0800_0000, 1'b0, TP, 1'b0);
    endtask
    task automatic tally_and_finish;
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        t_normal();
        t_wprot();
        t_rdprot();
        t_bad_and_monitor();
        tally_and_finish();
    end
    // whole run needs well under a thousand cycles
    initial
    begin
        #100000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
